// [include/adc_conversion_control_defines.vh]
// constants for the converter control block: offsets, fields, resets, timing
// assumes a 20 MHz system clock and an APB master with 12-bit addresses
//
// Notes on behaviour
// - twelve inputs small package, sixteen large
// - each conversion yields a ten-bit result
// - acquire for programmed time, then convert
// - channel select and start in one write
// - bits 5..2 of control zero pick channel
// - small package: codes 12..15 have no input
// - bit 1 starts, reads busy, hardware clears
// - bit 0 enables the converter module
// - control zero bits 7..6 read zero
// - result split over high and low bytes
// - port config sets each pin analog/digital
// - timing config: clock, justification, acquisition
// - nonzero code n makes top n+1 digital
`ifndef ADC_CONVERSION_CONTROL_DEFINES_VH
`define ADC_CONVERSION_CONTROL_DEFINES_VH

// ==========================================================================
// register offsets (byte addresses)
`define ADC_OFS_CONTROL_ZERO  12'h000
`define ADC_OFS_PORT_CONFIG   12'h004
`define ADC_OFS_TIMING_CONFIG 12'h008
`define ADC_OFS_RESULT_HIGH   12'h00C
`define ADC_OFS_RESULT_LOW    12'h010

// ==========================================================================
// control zero fields
`define ADC_CZ_ENABLE_BIT     0
`define ADC_CZ_GO_BIT         1
`define ADC_CZ_CHAN_LSB       2
`define ADC_CZ_CHAN_MSB       5

// port config fields
`define ADC_PC_PCFG_LSB       0
`define ADC_PC_PCFG_MSB       3
`define ADC_PC_VREF_LSB       4
`define ADC_PC_VREF_MSB       5

// timing config fields
`define ADC_TC_CLKSEL_LSB     0
`define ADC_TC_CLKSEL_MSB     2
`define ADC_TC_ACQ_LSB        3
`define ADC_TC_ACQ_MSB        5
`define ADC_TC_JUSTIFY_BIT    7

// ==========================================================================
// reset values
`define ADC_RST_CONTROL_ZERO  8'h00
`define ADC_RST_PORT_CONFIG   8'h00
`define ADC_RST_TIMING_CONFIG 8'h00
`define ADC_RST_RESULT        8'h00

// ==========================================================================
// timing: one conversion clock period is TAD_BASE shifted by clock select
`define ADC_TAD_BASE_CYCLES   11'h008
`define ADC_ACQ_TAD_PER_STEP  2
`define ADC_RESULT_BITS       10

`endif

// [logic/pin_sync_filter.v]
// three-stage synchroniser with agreement filter for one pin input
// assumes the pin is asynchronous to clock; output changes only when
// the second and third stages agree
`default_nettype none

module pin_sync_filter (
	input  wire clock,
	input  wire reset_n,
	input  wire pinIn,
	output reg  pinOut
);

	reg stageA_r;
	reg stageB_r;
	reg stageC_r;

	// ======================================================================
	// synchroniser chain and filter
	always @(posedge clock) begin
		if (!reset_n) begin
			stageA_r <= 1'b0;
			stageB_r <= 1'b0;
			stageC_r <= 1'b0;
			pinOut   <= 1'b0;
		end else begin
			stageA_r <= pinIn;
			stageB_r <= stageA_r;
			stageC_r <= stageB_r;
			if (stageB_r == stageC_r) begin
				pinOut <= stageC_r;
			end
		end
	end

endmodule // pin_sync_filter

`default_nettype wire

// [logic/adc_conversion_control.v]
// converter control: APB registers, acquisition timer, successive
// approximation sequencer; assumes an external sample switch, analog
// multiplexer, DAC and comparator (compareIn high when input >= dacCode)
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`default_nettype none
`include "adc_conversion_control_defines.vh"

module adc_conversion_control #(
	parameter CHANNEL_COUNT = 16,
	parameter ADDR_WIDTH    = 12
) (
	input  wire                  clock,
	input  wire                  reset_n,
	input  wire                  psel,
	input  wire                  penable,
	input  wire                  pwrite,
	input  wire [ADDR_WIDTH-1:0] paddr,
	input  wire [31:0]           pwdata,
	output reg  [31:0]           prdata,
	output wire                  pready,
	output wire                  pslverr,
	input  wire                  compareIn,
	output reg  [3:0]            channelSelect,
	output wire                  channelValid,
	output wire                  converterPowered,
	output reg                   sampleEnable,
	output reg  [9:0]            dacCode,
	output reg  [15:0]           analogPinMask,
	output wire [1:0]            vrefSelect
);

	// ======================================================================
	// sequencer states
	localparam ST_IDLE  = 3'd0;
	localparam ST_ACQ   = 3'd1;
	localparam ST_TRIAL = 3'd2;
	localparam ST_STORE = 3'd3;
	localparam ST_DONE  = 3'd4;

	reg        enable_r;
	reg        go_r;
	reg [5:0]  portCfg_r;
	reg [7:0]  timingCfg_r;
	reg [7:0]  resultHigh_r;
	reg [7:0]  resultLow_r;
	reg [2:0]  state_r;
	reg [2:0]  state_nxt;
	reg [10:0] tadCnt_r;
	reg [3:0]  tadNum_r;
	reg [3:0]  bitIdx_r;
	reg [9:0]  result_r;
	wire       compareSeen;
	wire       apbSetup;
	wire       apbWrite;
	wire       hitCz;
	wire       hitPc;
	wire       hitTc;
	wire       hitRh;
	wire       hitRl;
	wire       hitAny;
	wire       swStart;
	wire [10:0] tadLen;
	wire       tadTick;
	wire [3:0] acqTads;
	wire [3:0] pcfg;
	reg  [7:0] rdByte;
	wire [7:0]  czReset;
	wire [7:0]  pcReset;
	wire [31:0] acqProd;
	wire [4:0]  digitalTop;

	// ======================================================================
	// comparator pin synchroniser
	pin_sync_filter u_compareSync (
		.clock   (clock),
		.reset_n (reset_n),
		.pinIn   (compareIn),
		.pinOut  (compareSeen)
	);

	// ======================================================================
	// APB decode
	assign apbSetup = psel & ~penable;
	assign apbWrite = psel & penable & pwrite;
	assign hitCz    = (paddr == `ADC_OFS_CONTROL_ZERO);
	assign hitPc    = (paddr == `ADC_OFS_PORT_CONFIG);
	assign hitTc    = (paddr == `ADC_OFS_TIMING_CONFIG);
	assign hitRh    = (paddr == `ADC_OFS_RESULT_HIGH);
	assign hitRl    = (paddr == `ADC_OFS_RESULT_LOW);
	assign hitAny   = hitCz | hitPc | hitTc | hitRh | hitRl;
	assign pready   = 1'b1;
	assign pslverr  = psel & penable & ~hitAny;

	// start taken with the enable written alongside it
	assign swStart = apbWrite & hitCz & pwdata[`ADC_CZ_GO_BIT] &
		pwdata[`ADC_CZ_ENABLE_BIT];

	// ======================================================================
	// reset images of control zero and port config
	assign czReset = `ADC_RST_CONTROL_ZERO;
	assign pcReset = `ADC_RST_PORT_CONFIG;

	// ======================================================================
	// control zero
	always @(posedge clock) begin
		if (!reset_n) begin
			enable_r      <= czReset[`ADC_CZ_ENABLE_BIT];
			channelSelect <= czReset[`ADC_CZ_CHAN_MSB:`ADC_CZ_CHAN_LSB];
		end else if (apbWrite && hitCz) begin
			enable_r      <= pwdata[`ADC_CZ_ENABLE_BIT];
			channelSelect <= pwdata[`ADC_CZ_CHAN_MSB:`ADC_CZ_CHAN_LSB];
		end
	end

	// start/busy: software sets, hardware clears, set wins
	always @(posedge clock) begin
		if (!reset_n) begin
			go_r <= czReset[`ADC_CZ_GO_BIT];
		end else if (swStart) begin
			go_r <= 1'b1;
		// switching the module off aborts a running conversion
		end else if (apbWrite && hitCz && !pwdata[`ADC_CZ_ENABLE_BIT]) begin
			go_r <= 1'b0;
		end else if (state_r == ST_DONE) begin
			go_r <= 1'b0;
		end
	end

	// ======================================================================
	// configuration registers
	always @(posedge clock) begin
		if (!reset_n) begin
			portCfg_r   <= pcReset[5:0];
			timingCfg_r <= `ADC_RST_TIMING_CONFIG;
		end else begin
			if (apbWrite && hitPc) begin
				portCfg_r <= pwdata[5:0];
			end
			if (apbWrite && hitTc) begin
				timingCfg_r <= {pwdata[7], 1'b0, pwdata[5:0]};
			end
		end
	end

	assign pcfg             = portCfg_r[`ADC_PC_PCFG_MSB:`ADC_PC_PCFG_LSB];
	assign vrefSelect       = portCfg_r[`ADC_PC_VREF_MSB:`ADC_PC_VREF_LSB];
	assign converterPowered = enable_r;

	// code zero keeps all analog, code n frees the top n+1 pins
	assign digitalTop = (pcfg == 4'h0) ? 5'h00 : {1'b0, pcfg} + 5'h01;

	always @(posedge clock) begin : pinMask
		integer i;
		if (!reset_n) begin
			analogPinMask <= 16'h0000;
		end else begin
			for (i = 0; i < 16; i = i + 1) begin
				analogPinMask[i] <= (i < 16 - digitalTop) && (i < CHANNEL_COUNT);
			end
		end
	end

	// codes beyond the fitted channels select no input
	assign channelValid = ({1'b0, channelSelect} < CHANNEL_COUNT);

	// ======================================================================
	// conversion clock period and acquisition length
	assign tadLen  = `ADC_TAD_BASE_CYCLES <<
		timingCfg_r[`ADC_TC_CLKSEL_MSB:`ADC_TC_CLKSEL_LSB];
	assign tadTick = (tadCnt_r == tadLen - 11'd1);
	assign acqProd = {29'h0, timingCfg_r[`ADC_TC_ACQ_MSB:`ADC_TC_ACQ_LSB]} *
		`ADC_ACQ_TAD_PER_STEP;
	// a three-bit field times two always fits four bits
	assign acqTads = acqProd[3:0];

	// restart the divider on every state change
	always @(posedge clock) begin
		if (!reset_n || state_r != state_nxt || tadTick) begin
			tadCnt_r <= 11'h000;
		end else begin
			tadCnt_r <= tadCnt_r + 11'd1;
		end
	end

	// ======================================================================
	// sequencer next state
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (swStart) begin
					state_nxt = ST_ACQ;
				end
			end
			// wait out acquisition before the first trial
			ST_ACQ: begin
				if (tadNum_r >= acqTads) begin
					state_nxt = ST_TRIAL;
				end
			end
			ST_TRIAL: begin
				if (tadTick && bitIdx_r == 4'd0) begin
					state_nxt = ST_STORE;
				end
			end
			ST_STORE: begin
				state_nxt = ST_DONE;
			end
			ST_DONE: begin
				state_nxt = swStart ? ST_ACQ : ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
		// a start that also switches the module on must not be dropped
		if (!enable_r && !swStart) begin
			state_nxt = ST_IDLE;
		end
	end

	// ======================================================================
	// sequencer datapath
	always @(posedge clock) begin
		if (!reset_n) begin
			state_r      <= ST_IDLE;
			tadNum_r     <= 4'h0;
			bitIdx_r     <= 4'd9;
			dacCode      <= 10'h000;
			result_r     <= 10'h000;
			sampleEnable <= 1'b0;
		end else begin
			state_r      <= state_nxt;
			sampleEnable <= (state_nxt == ST_ACQ);
			if (state_nxt == ST_ACQ && state_r != ST_ACQ) begin
				tadNum_r <= 4'h0;
			end else if (state_r == ST_ACQ && tadTick) begin
				tadNum_r <= tadNum_r + 4'd1;
			end
			if (state_nxt == ST_TRIAL && state_r != ST_TRIAL) begin
				bitIdx_r <= 4'd9;
				dacCode  <= 10'h200;
			end else if (state_r == ST_TRIAL && tadTick) begin
				// keep or drop the trial bit, try the next lower
				dacCode[bitIdx_r] <= compareSeen;
				if (bitIdx_r != 4'd0) begin
					dacCode[bitIdx_r - 4'd1] <= 1'b1;
					bitIdx_r <= bitIdx_r - 4'd1;
				end else begin
					result_r <= {dacCode[9:1], compareSeen};
				end
			end
		end
	end

	// ======================================================================
	// result bytes land one cycle before busy clears
	always @(posedge clock) begin
		if (!reset_n) begin
			resultHigh_r <= `ADC_RST_RESULT;
			resultLow_r  <= `ADC_RST_RESULT;
		end else if (state_r == ST_STORE) begin
			if (timingCfg_r[`ADC_TC_JUSTIFY_BIT]) begin
				resultHigh_r <= {6'b00_0000, result_r[9:8]};
				resultLow_r  <= result_r[7:0];
			end else begin
				resultHigh_r <= result_r[9:2];
				resultLow_r  <= {result_r[1:0], 6'b00_0000};
			end
		end
	end

	// ======================================================================
	// read mux, captured in the setup phase
	always @* begin
		rdByte = 8'h00;
		if (hitCz) begin
			rdByte = {2'b00, channelSelect, go_r, enable_r};
		end else if (hitPc) begin
			rdByte = {2'b00, portCfg_r};
		end else if (hitTc) begin
			rdByte = timingCfg_r;
		end else if (hitRh) begin
			rdByte = resultHigh_r;
		end else if (hitRl) begin
			rdByte = resultLow_r;
		end
	end

	always @(posedge clock) begin
		if (!reset_n) begin
			prdata <= 32'h0000_0000;
		end else if (apbSetup) begin
			prdata <= {24'h00_0000, rdByte};
		end
	end

endmodule // adc_conversion_control

`default_nettype wire

// [logic/dummy_unused_marker.v]
`default_nettype none
`default_nettype wire

// [verif/adc_analog_model.sv]
// comparator and input level model facing the converter control
// assumes level is held steady by the bench during a conversion
`default_nettype none
module adc_analog_model (
	input wire logic       clock,
	input wire logic [9:0] level,
	input wire logic [9:0] dacCode,
	input wire logic       slow,
	output logic           compareIn
);
	timeunit 1ns;
	timeprecision 1ns;
	logic d1, d2;
	always @(posedge clock) begin
		d1 <= level >= dacCode;
		d2 <= d1;
	end
	// slow mode lags the comparator by two cycles
	assign compareIn = slow ? d2 : (level >= dacCode);
endmodule // adc_analog_model
`default_nettype wire

// [verif/adc_conversion_control_checker.sv]
// port-level assertions for the converter control
// assumes ADDR_WIDTH 12 and byte offsets 0x00..0x10
`default_nettype none
module adc_conversion_control_checker #(
	parameter CHANNEL_COUNT = 16,
	parameter ADDR_WIDTH    = 12
) (
	input wire logic                  clock,
	input wire logic                  reset_n,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0]           pwdata,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic                  compareIn,
	input wire logic [3:0]            channelSelect,
	input wire logic                  channelValid,
	input wire logic                  converterPowered,
	input wire logic                  sampleEnable,
	input wire logic [9:0]            dacCode,
	input wire logic [15:0]           analogPinMask,
	input wire logic [1:0]            vrefSelect
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	function automatic logic [15:0] pinMask(input logic [3:0] c);
		if (c == 4'h0) begin
			pinMask = 16'((32'h1 << CHANNEL_COUNT) - 1);
		end else begin
			pinMask = 16'(((32'h1 << (15 - c)) - 1)
				& ((32'h1 << CHANNEL_COUNT) - 1));
		end
	endfunction
	// ==========================================================
	// access sequences
	sequence czWr;
		psel && penable && pwrite && paddr == 12'h000;
	endsequence
	sequence pcWr;
		psel && penable && pwrite && paddr == 12'h004;
	endsequence
	chk_ready_high: assert property (pready)
		else $error("ready low");
	chk_err_unmapped: assert property (psel && penable
		&& paddr > 12'h010 |-> pslverr) else $error("no error");
	chk_unimpl_zero: assert property (
		psel && penable && !pwrite && paddr == 12'h000
		|-> prdata[7:6] == 2'b00) else $error("bits 7:6 set");
	chk_chan_write: assert property (
		czWr |=> channelSelect == $past(pwdata[5:2]))
		else $error("channel not taken");
	chk_chan_valid: assert property (
		channelValid == (channelSelect < CHANNEL_COUNT))
		else $error("channel valid wrong");
	chk_enable_write: assert property (
		czWr |=> converterPowered == $past(pwdata[0]))
		else $error("enable wrong");
	chk_start_ignored: assert property (
		czWr ##0 (!converterPowered && !pwdata[0])
		|=> !sampleEnable [*4]) else $error("start while off");
	chk_start_acq: assert property (
		czWr ##0 (pwdata[1:0] == 2'b11 && !converterPowered)
		|=> ##[0:1] sampleEnable) else $error("no acquisition");
	chk_trial_msb: assert property (
		$fell(sampleEnable) && converterPowered
		|-> ##[0:2] dacCode == 10'h200) else $error("no trial");
	chk_pin_mask: assert property (
		pcWr |=> ##1 analogPinMask == pinMask($past(pwdata[3:0], 2)))
		else $error("pin mask wrong");
	chk_vref_write: assert property (
		pcWr |=> vrefSelect == $past(pwdata[5:4]))
		else $error("vref wrong");
endmodule // adc_conversion_control_checker
bind adc_conversion_control adc_conversion_control_checker #(
	.CHANNEL_COUNT(CHANNEL_COUNT), .ADDR_WIDTH(ADDR_WIDTH)) chk_i (
	.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .compareIn(compareIn),
	.channelSelect(channelSelect), .channelValid(channelValid),
	.converterPowered(converterPowered), .sampleEnable(sampleEnable),
	.dacCode(dacCode), .analogPinMask(analogPinMask),
	.vrefSelect(vrefSelect));
`default_nettype wire

// [verif/test_adc_conversion_control.sv]
// self-checking bench for the converter control, small package
// assumes the checker is bound and the analog model answers
`default_nettype none
`define CHK(n, e, s) begin checkCount++; if ((s) !== (e)) begin \
	fails++; $display("unexpected %s exp %0h got %0h", n, e, s); end end
module test_adc_conversion_control;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock = 0, reset_n = 0, psel = 0, penable = 0;
	logic        pwrite = 0, slow = 0, err;
	logic        pready, pslverr, compareIn, channelValid;
	logic        converterPowered, sampleEnable;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [9:0]  dacCode, level = 0;
	logic [3:0]  channelSelect;
	logic [15:0] analogPinMask;
	logic [1:0]  vrefSelect;
	int          fails = 0, checkCount = 0;
	always #25 clock = ~clock;
	adc_conversion_control #(.CHANNEL_COUNT(12)) adc_conversion_control_i (
		.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .compareIn(compareIn),
		.channelSelect(channelSelect), .channelValid(channelValid),
		.converterPowered(converterPowered), .sampleEnable(sampleEnable),
		.dacCode(dacCode), .analogPinMask(analogPinMask),
		.vrefSelect(vrefSelect));
	adc_analog_model adc_analog_model_i (.clock(clock), .level(level),
		.dacCode(dacCode), .slow(slow), .compareIn(compareIn));
	// ==========================================================
	// bus and closing tasks
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge clock);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clock);
		penable <= 1;
		@(posedge clock);
		while (pready !== 1'b1) @(posedge clock);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task tallyAndFinish;
		$display("checks %0d mismatches %0d", checkCount, fails);
		if (fails == 0 && checkCount > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ==========================================================
	// scenarios
	task tResets;
		for (int i = 0; i < 5; i++) begin
			apb(0, 12'(i * 4), 8'h00);
			`CHK("reset", 8'h00, rd[7:0])
		end
		$display("reset test done");
	endtask
	task tControl;
		apb(1, 12'h000, 8'hFE);
		apb(0, 12'h000, 8'h00);
		`CHK("control", 8'h3C, rd[7:0])
		`CHK("powered", 1'b0, converterPowered)
		for (int i = 0; i < 16; i++) begin
			apb(1, 12'h000, {2'b00, 4'(i), 2'b00});
			@(negedge clock);
			`CHK("chan", 4'(i), channelSelect)
			`CHK("valid", i < 12, channelValid)
		end
		$display("control test done");
	endtask
	task tPortConfig;
		logic [15:0] expMask;
		for (int i = 0; i < 16; i++) begin
			apb(1, 12'h004, {2'b00, 2'(i), 4'(i)});
			apb(0, 12'h004, 8'h00);
			`CHK("portcfg", {2'b00, 2'(i), 4'(i)}, rd[7:0])
			expMask = (i == 0) ? 16'h0FFF :
				16'((32'h1 << (15 - i)) - 1) & 16'h0FFF;
			`CHK("pin mask", expMask, analogPinMask)
			`CHK("vref", 2'(i), vrefSelect)
		end
		$display("port config test done");
	endtask
	task convert(input logic [3:0] ch, input logic [9:0] lv,
		input logic just);
		int n;
		level <= lv;
		apb(1, 12'h008, {just, 7'h08});
		apb(1, 12'h000, {2'b00, ch, 2'b11});
		apb(0, 12'h000, 8'h00);
		`CHK("busy", 1'b1, rd[1])
		n = 0;
		while (rd[1] === 1'b1 && n < 300) begin
			apb(0, 12'h000, 8'h00);
			n++;
		end
		`CHK("done", 1'b0, rd[1])
		apb(0, 12'h00C, 8'h00);
		`CHK("high", just ? {6'b0, lv[9:8]} : lv[9:2], rd[7:0])
		apb(0, 12'h010, 8'h00);
		`CHK("low", just ? lv[7:0] : {lv[1:0], 6'b0}, rd[7:0])
		$display("convert test done");
	endtask
	task tAbort;
		apb(1, 12'h000, 8'h0F);
		apb(1, 12'h000, 8'h0C);
		apb(0, 12'h000, 8'h00);
		`CHK("abort", 8'h0C, rd[7:0])
		`CHK("powered off", 1'b0, converterPowered)
		apb(0, 12'h020, 8'h00);
		`CHK("unmapped err", 1'b1, err)
		`CHK("unmapped data", 32'h0, rd)
		$display("abort test done");
	endtask
	initial begin
		repeat (10) @(posedge clock);
		reset_n <= 1;
		tResets;
		tControl;
		tPortConfig;
		convert(4'h3, 10'h2A5, 1);
		convert(4'h0, 10'h3FF, 0);
		slow <= 1;
		convert(4'hB, 10'h15A, 0);
		tAbort;
		tallyAndFinish;
	end
	// watchdog: far beyond the few hundred cycles the tests need
	initial begin
		#2000000;
		fails++;
		tallyAndFinish;
	end
endmodule // test_adc_conversion_control
`default_nettype wire
